// ===== verilog/cssc_pkg.sv
package cssc_pkg;
    localparam int NUM_SLOTS = 2;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;
    localparam int SYNC_W = 23;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_RDATA = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    localparam int CTRL_IO_MODE = 0;
    localparam int CTRL_AUDIO_EN = 1;
    localparam int CTRL_CARD_RESET = 2;
    localparam int CTRL_STRIDE = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    localparam int CMD_SLOT = 0;
    localparam int CMD_SPACE_LO = 1;
    localparam int CMD_WRITE = 3;
    localparam int CMD_BE_LO = 4;

    localparam int STAT_PRESENT = 0;
    localparam int STAT_INS1 = 1;
    localparam int STAT_INS2 = 2;
    localparam int STAT_BATT_LO = 3;
    localparam int STAT_READY = 5;
    localparam int STAT_WP = 6;
    localparam int STAT_WAIT = 7;
    localparam int STAT_STRIDE = 8;
    localparam int STAT_BUSY = 16;

    typedef enum logic [1:0] {SPACE_COMMON, SPACE_ATTR, SPACE_IO} cssc_space_type;
    typedef enum logic [1:0] {BATT_GOOD, BATT_WEAK, BATT_DEAD} cssc_batt_type;

    localparam int CLK_PERIOD_NS = 100;
    localparam int SETUP_NS = 100;
    localparam int STROBE_NS = 300;
    localparam int HOLD_NS = 100;
    localparam logic [2:0] SETUP_CYC = 3'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] STROBE_CYC = 3'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] HOLD_CYC = 3'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ===== verilog/cssc_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cssc_cyc_if;
    logic start;
    cssc_pkg::cssc_space_type space;
    logic write;
    logic [1:0] be;
    logic [cssc_pkg::ADDR_W-1:0] addr;
    logic [cssc_pkg::DATA_W-1:0] wdata;
    logic busy;
    logic done;
    logic [cssc_pkg::DATA_W-1:0] rdata;
    modport ctl (output start, space, write, be, addr, wdata, input busy, done, rdata);
    modport eng (input start, space, write, be, addr, wdata, output busy, done, rdata);
endinterface
`default_nettype wire

// ===== verilog/cssc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cssc_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/cssc_engine.sv
`timescale 1ns/1ps
`default_nettype none
module cssc_engine (
    input wire logic sys_clk,
    input wire logic reset_n,
    cssc_cyc_if.eng cyc,
    input wire logic wait_s,
    input wire logic [cssc_pkg::DATA_W-1:0] data_s,
    output logic [cssc_pkg::ADDR_W-1:0] addr_r,
    output logic [cssc_pkg::DATA_W-1:0] data_o_r,
    output logic [cssc_pkg::DATA_W-1:0] data_oe_r,
    output logic ce_even_n_r,
    output logic ce_odd_n_r,
    output logic reg_n_r,
    output logic oe_n_r,
    output logic we_n_r,
    output logic io_rd_n_r,
    output logic io_wr_n_r
);
    typedef enum logic [1:0] {ENG_IDLE, ENG_SETUP, ENG_STROBE, ENG_HOLD} cssc_eng_type;
    cssc_eng_type state_r;
    logic [2:0] cnt_r;
    logic is_io_r;
    logic write_r;
    logic strobe_nxt;
    logic strobe_end;
    logic done_r;
    logic [cssc_pkg::DATA_W-1:0] rdata_r;

    assign cyc.busy = (state_r != ENG_IDLE);
    assign cyc.done = done_r;
    assign cyc.rdata = rdata_r;
    // A wait that reaches the synchroniser output after the last strobe count does not hold the strobe, so cards must raise it early.
    assign strobe_end = (state_r == ENG_STROBE) && (cnt_r == 3'h0) && !wait_s;
    assign strobe_nxt = ((state_r == ENG_SETUP) && (cnt_r == 3'h0))
        || ((state_r == ENG_STROBE) && !strobe_end);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ENG_IDLE;
            cnt_r <= 3'h0;
        end else begin
            case (state_r)
                ENG_IDLE: begin
                    if (cyc.start) begin
                        state_r <= ENG_SETUP;
                        cnt_r <= cssc_pkg::SETUP_CYC - 3'h1;
                    end
                end
                ENG_SETUP: begin
                    if (cnt_r == 3'h0) begin
                        state_r <= ENG_STROBE;
                        cnt_r <= cssc_pkg::STROBE_CYC - 3'h1;
                    end else begin
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
                ENG_STROBE: begin
                    if (strobe_end) begin
                        state_r <= ENG_HOLD;
                        cnt_r <= cssc_pkg::HOLD_CYC - 3'h1;
                    end else if (cnt_r != 3'h0) begin
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
                ENG_HOLD: begin
                    if (cnt_r == 3'h0) begin
                        state_r <= ENG_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
                default: state_r <= ENG_IDLE;
            endcase
        end
    end

    // Address loads only in idle; enables and space select load in idle and release at the end of hold, so they hold under any strobe.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_r <= '0;
            ce_even_n_r <= 1'b1;
            ce_odd_n_r <= 1'b1;
            reg_n_r <= 1'b1;
            is_io_r <= 1'b0;
            write_r <= 1'b0;
            data_o_r <= '0;
            data_oe_r <= '0;
        end else if (state_r == ENG_IDLE && cyc.start) begin
            addr_r <= cyc.addr;
            ce_even_n_r <= !cyc.be[0];
            ce_odd_n_r <= !cyc.be[1];
            reg_n_r <= (cyc.space != cssc_pkg::SPACE_ATTR) && (cyc.space != cssc_pkg::SPACE_IO);
            is_io_r <= (cyc.space == cssc_pkg::SPACE_IO);
            write_r <= cyc.write;
            data_o_r <= cyc.wdata;
            data_oe_r <= {cssc_pkg::DATA_W{cyc.write}};
        end else if (state_r == ENG_HOLD && cnt_r == 3'h0) begin
            ce_even_n_r <= 1'b1;
            ce_odd_n_r <= 1'b1;
            reg_n_r <= 1'b1;
            data_oe_r <= '0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            io_rd_n_r <= 1'b1;
            io_wr_n_r <= 1'b1;
        end else begin
            oe_n_r <= !(strobe_nxt && !is_io_r && !write_r);
            we_n_r <= !(strobe_nxt && !is_io_r && write_r);
            io_rd_n_r <= !(strobe_nxt && is_io_r && !write_r);
            io_wr_n_r <= !(strobe_nxt && is_io_r && write_r);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= (state_r == ENG_HOLD) && (cnt_r == 3'h0);
            if (strobe_end && !write_r) begin
                rdata_r <= data_s;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_io_read_strobe: assert property (
        (cyc.start && !cyc.busy && cyc.space == cssc_pkg::SPACE_IO && !cyc.write)
        |-> ##2 (!io_rd_n_r && io_wr_n_r && oe_n_r && we_n_r))
        else $error("io read strobe not asserted");
    chk_io_write_strobe: assert property (
        (cyc.start && !cyc.busy && cyc.space == cssc_pkg::SPACE_IO && cyc.write)
        |-> ##2 (!io_wr_n_r && !reg_n_r && data_oe_r == '1))
        else $error("io write strobe not asserted");
    chk_mem_read_oe: assert property (
        (cyc.start && !cyc.busy && cyc.space != cssc_pkg::SPACE_IO && !cyc.write)
        |-> ##2 (!oe_n_r ##1 !oe_n_r))
        else $error("output enable not asserted for memory read");
    chk_mem_write_we: assert property (
        (cyc.start && !cyc.busy && cyc.space != cssc_pkg::SPACE_IO && cyc.write)
        |-> ##2 !we_n_r[*3] ##1 we_n_r)
        else $error("write strobe pulse wrong");
    chk_strobe_addr_stable: assert property (
        (!(oe_n_r && we_n_r && io_rd_n_r && io_wr_n_r)) |=>
        ((oe_n_r && we_n_r && io_rd_n_r && io_wr_n_r)
        || ($stable(addr_r) && $stable(ce_even_n_r) && $stable(reg_n_r))))
        else $error("address moved under strobe");
    chk_wait_extends: assert property (
        (state_r == ENG_STROBE && wait_s) |=> (state_r == ENG_STROBE) && !cyc.done)
        else $error("cycle ended while wait asserted");
    chk_common_reg_high: assert property (
        (cyc.start && !cyc.busy && cyc.space == cssc_pkg::SPACE_COMMON) |=> reg_n_r[*4])
        else $error("attribute select low in common access");
    chk_byte_enable: assert property (
        (cyc.start && !cyc.busy) |=> (ce_even_n_r == !$past(cyc.be[0]))
        && (ce_odd_n_r == !$past(cyc.be[1])))
        else $error("byte enables wrong");
    cov_io_read: cover property (!io_rd_n_r ##1 io_rd_n_r);
    cov_mem_write: cover property (!we_n_r ##1 we_n_r);
    cov_wait_stretch: cover property (state_r == ENG_STROBE && wait_s ##1 strobe_end);
endmodule
`default_nettype wire

// ===== verilog/cssc_top.sv
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Battery inputs: both high good, two low weak, one low dead.
// - Battery detect two is audio only in I/O mode, else battery status.
// - Binary audio from both slots combines onto one output pin.
// - Each socket gets a 26-bit address, top line most significant.
// - Cards ground both insertion detects; software reads them in status.
// - Data moves over a 16-bit two-way bus, top line most significant.
// - First enable selects even bytes, second enable selects odd bytes.
// - I/O reads drive the I/O read strobe low.
// - I/O writes drive the I/O write strobe low.
// - Memory reads drive the output enable low.
// - Attribute select high for common memory, low for attribute and I/O.
// - Input acknowledge from the card is not used.
// - Memory writes pulse the write strobe.
// - Card wait stretches the cycle; no completion while wait holds.
// - Each slot has a card reset output.
module cssc_top (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [1:0][cssc_pkg::ADDR_W-1:0] socket_address_bus,
    output logic [1:0][cssc_pkg::DATA_W-1:0] socket_data_bus_o,
    output logic [1:0][cssc_pkg::DATA_W-1:0] socket_data_bus_oe,
    input wire logic [1:0][cssc_pkg::DATA_W-1:0] socket_data_bus_i,
    output logic [1:0] even_byte_enable_n,
    output logic [1:0] odd_byte_enable_n,
    output logic [1:0] output_enable_n,
    output logic [1:0] write_strobe_n,
    output logic [1:0] io_read_strobe_n,
    output logic [1:0] io_write_strobe_n,
    output logic [1:0] attribute_select_n,
    output logic [1:0] card_reset,
    input wire logic [1:0] insertion_detect_one_n,
    input wire logic [1:0] insertion_detect_two_n,
    input wire logic [1:0] battery_detect_one,
    input wire logic [1:0] battery_detect_two,
    input wire logic [1:0] memory_ready_busy,
    input wire logic [1:0] card_wait_n,
    input wire logic [1:0] write_protect,
    input wire logic [1:0] input_acknowledge_n,
    output logic combined_audio_out
);
    logic [31:0] ctrl_r;
    logic [cssc_pkg::ADDR_W-1:0] addr_r;
    logic [cssc_pkg::DATA_W-1:0] wdata_r;
    logic [31:0] cmd_r;
    logic launch_r;
    logic [cssc_pkg::DATA_W-1:0] rdata_r;
    logic [1:0] busy;
    logic [1:0] done;
    logic [1:0][cssc_pkg::DATA_W-1:0] eng_rdata;
    logic [1:0][7:0] slot_stat;
    logic [1:0] audio_term;

    logic [1:0] ins1_s;
    logic [1:0] ins2_s;
    logic [1:0] bat1_s;
    logic [1:0] bat2_s;
    logic [1:0] rdy_s;
    logic [1:0] wait_s;
    logic [1:0] wp_s;
    logic [1:0][cssc_pkg::DATA_W-1:0] data_s;

    // Battery state from the two detect inputs; detect one low wins over everything.
    function automatic cssc_pkg::cssc_batt_type batt_decode(input logic bat1, input logic bat2);
        if (!bat1) begin
            batt_decode = cssc_pkg::BATT_DEAD;
        end else if (!bat2) begin
            batt_decode = cssc_pkg::BATT_WEAK;
        end else begin
            batt_decode = cssc_pkg::BATT_GOOD;
        end
    endfunction

    function automatic logic slot_bit(input logic [31:0] word, input int s, input int pos);
        slot_bit = word[s * cssc_pkg::CTRL_STRIDE + pos];
    endfunction

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= cssc_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == cssc_pkg::OFS_CTRL) begin
            ctrl_r <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_r <= '0;
            wdata_r <= '0;
        end else if (reg_wr && reg_addr == cssc_pkg::OFS_ADDR) begin
            addr_r <= reg_wdata[cssc_pkg::ADDR_W-1:0];
        end else if (reg_wr && reg_addr == cssc_pkg::OFS_WDATA) begin
            wdata_r <= reg_wdata[cssc_pkg::DATA_W-1:0];
        end
    end

    // A command written while the chosen slot is still busy is dropped, not queued.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_r <= 32'h0000_0000;
            launch_r <= 1'b0;
        end else begin
            launch_r <= 1'b0;
            if (reg_wr && reg_addr == cssc_pkg::OFS_CMD && !launch_r
                && !busy[reg_wdata[cssc_pkg::CMD_SLOT]]) begin
                cmd_r <= reg_wdata;
                launch_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= '0;
        end else if (done[0]) begin
            rdata_r <= eng_rdata[0];
        end else if (done[1]) begin
            rdata_r <= eng_rdata[1];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                cssc_pkg::OFS_CTRL: reg_rdata <= ctrl_r;
                cssc_pkg::OFS_ADDR: reg_rdata <= {6'h00, addr_r};
                cssc_pkg::OFS_WDATA: reg_rdata <= {16'h0000, wdata_r};
                cssc_pkg::OFS_CMD: reg_rdata <= cmd_r;
                cssc_pkg::OFS_RDATA: reg_rdata <= {16'h0000, rdata_r};
                cssc_pkg::OFS_STATUS: reg_rdata <= {14'h0000, busy, slot_stat[1], slot_stat[0]};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    for (genvar s = 0; s < cssc_pkg::NUM_SLOTS; s++) begin : g_slot
        cssc_cyc_if cyc ();
        logic [cssc_pkg::SYNC_W-1:0] sync_vec;
        cssc_pkg::cssc_batt_type batt;

        // Input acknowledge is deliberately left out of the synchroniser and never read.
        // The stages clear to zero, so a socket reads as occupied for two cycles after reset.
        cssc_sync #(.W(cssc_pkg::SYNC_W)) u_sync (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .async_in({socket_data_bus_i[s], insertion_detect_one_n[s],
                insertion_detect_two_n[s], battery_detect_one[s], battery_detect_two[s],
                memory_ready_busy[s], !card_wait_n[s], write_protect[s]}),
            .sync_out(sync_vec)
        );
        assign data_s[s] = sync_vec[22:7];
        assign ins1_s[s] = sync_vec[6];
        assign ins2_s[s] = sync_vec[5];
        assign bat1_s[s] = sync_vec[4];
        assign bat2_s[s] = sync_vec[3];
        assign rdy_s[s] = sync_vec[2];
        assign wait_s[s] = sync_vec[1];
        assign wp_s[s] = sync_vec[0];

        assign cyc.start = launch_r && (cmd_r[cssc_pkg::CMD_SLOT] == 1'(s));
        assign cyc.space = cssc_pkg::cssc_space_type'(cmd_r[cssc_pkg::CMD_SPACE_LO +: 2]);
        assign cyc.write = cmd_r[cssc_pkg::CMD_WRITE];
        assign cyc.be = cmd_r[cssc_pkg::CMD_BE_LO +: 2];
        assign cyc.addr = addr_r;
        assign cyc.wdata = wdata_r;
        assign busy[s] = cyc.busy;
        assign done[s] = cyc.done;
        assign eng_rdata[s] = cyc.rdata;

        cssc_engine u_engine (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .cyc(cyc.eng),
            .wait_s(wait_s[s]),
            .data_s(data_s[s]),
            .addr_r(socket_address_bus[s]),
            .data_o_r(socket_data_bus_o[s]),
            .data_oe_r(socket_data_bus_oe[s]),
            .ce_even_n_r(even_byte_enable_n[s]),
            .ce_odd_n_r(odd_byte_enable_n[s]),
            .reg_n_r(attribute_select_n[s]),
            .oe_n_r(output_enable_n[s]),
            .we_n_r(write_strobe_n[s]),
            .io_rd_n_r(io_read_strobe_n[s]),
            .io_wr_n_r(io_write_strobe_n[s])
        );

        // In I/O mode the battery pins carry alert and audio, so the battery field reads good.
        assign batt = slot_bit(ctrl_r, s, cssc_pkg::CTRL_IO_MODE) ? cssc_pkg::BATT_GOOD
            : batt_decode(bat1_s[s], bat2_s[s]);

        assign slot_stat[s] = {wait_s[s], wp_s[s], rdy_s[s], batt,
            ins2_s[s], ins1_s[s], !ins1_s[s] && !ins2_s[s]};

        assign audio_term[s] = slot_bit(ctrl_r, s, cssc_pkg::CTRL_IO_MODE)
            && slot_bit(ctrl_r, s, cssc_pkg::CTRL_AUDIO_EN) && bat2_s[s];
    end

    // One process drives both reset bits, so no bit of the output has two writers.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            card_reset <= 2'h0;
        end else begin
            card_reset[0] <= slot_bit(ctrl_r, 0, cssc_pkg::CTRL_CARD_RESET);
            card_reset[1] <= slot_bit(ctrl_r, 1, cssc_pkg::CTRL_CARD_RESET);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            combined_audio_out <= 1'b0;
        end else begin
            combined_audio_out <= audio_term[0] ^ audio_term[1];
        end
    end

    // Audio reference built from control bits and pins, not from the mixing terms.
    logic audio_ref;
    assign audio_ref = (ctrl_r[cssc_pkg::CTRL_IO_MODE] && ctrl_r[cssc_pkg::CTRL_AUDIO_EN]
        && bat2_s[0]) ^ (ctrl_r[cssc_pkg::CTRL_STRIDE + cssc_pkg::CTRL_IO_MODE]
        && ctrl_r[cssc_pkg::CTRL_STRIDE + cssc_pkg::CTRL_AUDIO_EN] && bat2_s[1]);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_audio_xor_path: assert property (
        1'b1 |=> combined_audio_out == $past(audio_ref))
        else $error("combined audio not exclusive-OR of slots");

    chk_audio_idle_low: assert property (
        (ctrl_r[cssc_pkg::CTRL_IO_MODE] == 1'b0
        && ctrl_r[cssc_pkg::CTRL_STRIDE + cssc_pkg::CTRL_IO_MODE] == 1'b0)[*2]
        |-> !combined_audio_out)
        else $error("audio active with no slot in io mode");

    chk_battery_decode: assert property (
        (!ctrl_r[cssc_pkg::CTRL_IO_MODE] && !bat1_s[0] && reg_rd
        && reg_addr == cssc_pkg::OFS_STATUS)
        |=> reg_rdata[cssc_pkg::STAT_BATT_LO +: 2] == 2'(cssc_pkg::BATT_DEAD))
        else $error("dead battery not reported");

    chk_insert_status: assert property (
        (!ins1_s[1] && !ins2_s[1] && reg_rd && reg_addr == cssc_pkg::OFS_STATUS)
        |=> reg_rdata[cssc_pkg::STAT_STRIDE + cssc_pkg::STAT_PRESENT])
        else $error("inserted card not shown present");

    chk_card_reset: assert property (
        (reg_wr && reg_addr == cssc_pkg::OFS_CTRL)
        |=> ##1 card_reset[0] == $past(reg_wdata[cssc_pkg::CTRL_CARD_RESET], 2))
        else $error("card reset does not follow control");

    chk_read_one_cycle: assert property (
        (reg_rd && reg_addr == cssc_pkg::OFS_CTRL) |=> reg_rdata == ctrl_r ##1
        ($past(reg_rd) || reg_rdata == 32'h0000_0000))
        else $error("read data timing wrong");

    cov_audio_mix: cover property (combined_audio_out ##1 !combined_audio_out);
    cov_launch_busy: cover property (launch_r ##1 reg_wr && reg_addr == cssc_pkg::OFS_CMD);
endmodule
`default_nettype wire

// ===== test/cssc_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural card: one small store, split into two halves by the attribute select.
module cssc_card_model (
    input wire logic sys_clk,
    input wire logic [25:0] addr,
    input wire logic [15:0] dout,
    input wire logic [15:0] doe,
    output logic [15:0] din,
    input wire logic [6:0] pins,
    input wire logic [3:0] stall,
    output logic wait_n,
    output logic [6:0] seen,
    output logic moved
);
    logic [15:0] mem [32];
    logic [4:0] idx;
    logic strb, strb_q, wr_q, rd;
    logic [3:0] cnt;
    logic [25:0] addr_q;
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        seen = 7'h00;
        moved = 1'b0;
    end
    assign idx = {pins[6], addr[3:0]};
    assign rd = !(pins[5] & pins[4]) && !(pins[3] & pins[1]);
    assign strb = !(&pins[3:0]);
    // Outside a read strobe a released bus shows the inverse of the word, so a stale capture cannot pass.
    assign din = (dout & doe) | ((rd ? mem[idx] : ~mem[idx]) & ~doe);
    assign wait_n = !(strb && cnt < stall);
    always @(posedge sys_clk) begin
        strb_q <= strb;
        wr_q <= pins[2] & pins[0];
        cnt <= strb ? cnt + 4'h1 : 4'h0;
        if ((pins[2] & pins[0]) && !wr_q) mem[idx] <= din;
        if (strb && !strb_q) begin
            seen <= pins;
            addr_q <= addr;
        end
        if (strb && strb_q && addr !== addr_q) moved <= 1'b1;
    end
endmodule
`default_nettype wire

// ===== test/cssc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cssc_top_tb;
    logic sys_clk, reset_n, reg_wr, reg_rd, combined_audio_out;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, st;
    logic [1:0][25:0] socket_address_bus;
    logic [1:0][15:0] socket_data_bus_o, socket_data_bus_oe;
    logic [1:0] even_byte_enable_n, odd_byte_enable_n, output_enable_n, write_strobe_n;
    logic [1:0] io_read_strobe_n, io_write_strobe_n, attribute_select_n, card_reset;
    logic [1:0] insertion_detect_one_n, insertion_detect_two_n, battery_detect_one;
    logic [1:0] battery_detect_two, memory_ready_busy, write_protect, input_acknowledge_n;
    logic [1:0][3:0] stall;
    wire [1:0][15:0] socket_data_bus_i;
    wire [1:0][6:0] seen;
    wire [1:0] card_wait_n, moved;
    int errors, n_compared, polls;
    cssc_top cssc_top_inst (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .socket_address_bus, .socket_data_bus_o, .socket_data_bus_oe,
        .socket_data_bus_i, .even_byte_enable_n, .odd_byte_enable_n, .output_enable_n,
        .write_strobe_n, .io_read_strobe_n, .io_write_strobe_n, .attribute_select_n,
        .card_reset, .insertion_detect_one_n, .insertion_detect_two_n, .battery_detect_one,
        .battery_detect_two, .memory_ready_busy, .card_wait_n, .write_protect,
        .input_acknowledge_n, .combined_audio_out);
    for (genvar s = 0; s < 2; s++) begin : g_card
        cssc_card_model cssc_card_model_inst (.sys_clk, .addr(socket_address_bus[s]),
            .dout(socket_data_bus_o[s]), .doe(socket_data_bus_oe[s]),
            .din(socket_data_bus_i[s]), .pins({attribute_select_n[s],
            even_byte_enable_n[s], odd_byte_enable_n[s], output_enable_n[s],
            write_strobe_n[s], io_read_strobe_n[s], io_write_strobe_n[s]}),
            .stall(stall[s]), .wait_n(card_wait_n[s]), .seen(seen[s]), .moved(moved[s]));
    end
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 st = reg_rdata;
    endtask
    // One card cycle at a fixed address; waits on the busy flag, never on a fixed delay.
    task automatic cyc(input logic s, input logic [1:0] sp, input logic w,
            input logic [1:0] be, input logic [15:0] d, input logic [6:0] pins);
        wr(8'h04, 32'h0200_0001);
        wr(8'h08, {16'h0000, d});
        wr(8'h0c, {26'h000_0000, be, w, sp, s});
        for (polls = 0; polls < 40; polls++) begin
            rdx(8'h14);
            if (st[16 + s] === 1'b0) break;
        end
        if (polls == 40) begin
            errors++;
            $display("CHECK FAILED at %0t: card cycle never finished", $time);
            complete_run();
        end
        chk(32'(seen[s]), 32'(pins));
        chk(32'(socket_address_bus[s]), 32'h0200_0001);
    endtask
    initial begin
        {errors, n_compared, polls} = '0;
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, stall} = '0;
        {insertion_detect_one_n, insertion_detect_two_n} = 4'ha;
        {battery_detect_one, battery_detect_two} = 4'hf;
        memory_ready_busy = 2'b01;
        {write_protect, input_acknowledge_n} = 4'h0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdx(8'h00);
        chk(st, 32'h0000_0000);
        rdx(8'h24);
        chk(st, 32'h0000_0000);
        chk(32'({card_reset, write_strobe_n, output_enable_n}), 32'h0000_000f);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            battery_detect_one[0] <= (i < 2);
            battery_detect_two[0] <= (i == 0);
            repeat (3) @(posedge sys_clk);
            rdx(8'h14);
            chk(32'({st[13], st[8], st[5], st[4:3], st[0]}), 32'({3'h1, 2'(i), 1'b1}));
        end
        @(posedge sys_clk);
        insertion_detect_one_n <= 2'b00;
        insertion_detect_two_n <= 2'b00;
        $display("test status done");
        cyc(1'b0, 2'h0, 1'b1, 2'b10, 16'ha5c3, 7'h6b);
        cyc(1'b0, 2'h1, 1'b1, 2'b01, 16'h0f0f, 7'h1b);
        cyc(1'b0, 2'h0, 1'b0, 2'b11, 16'h0000, 7'h47);
        rdx(8'h10);
        chk(st, 32'h0000_a5c3);
        stall[0] <= 4'ha;
        cyc(1'b0, 2'h1, 1'b0, 2'b11, 16'h0000, 7'h07);
        chk(32'(polls > 4), 32'h0000_0001);
        stall[0] <= 4'h0;
        rdx(8'h10);
        chk(st, 32'h0000_0f0f);
        $display("test memory done");
        wr(8'h00, 32'h0000_0001);
        rdx(8'h14);
        chk(32'(st[4:3]), 32'h0000_0000);
        cyc(1'b0, 2'h2, 1'b1, 2'b11, 16'h1234, 7'h0e);
        cyc(1'b0, 2'h2, 1'b0, 2'b11, 16'h0000, 7'h0d);
        rdx(8'h10);
        chk(st, 32'h0000_1234);
        cyc(1'b1, 2'h0, 1'b1, 2'b11, 16'h5a5a, 7'h4b);
        cyc(1'b1, 2'h0, 1'b0, 2'b11, 16'h0000, 7'h47);
        rdx(8'h10);
        chk(st, 32'h0000_5a5a);
        $display("test io done");
        wr(8'h00, 32'h0000_0033);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            battery_detect_two <= 2'(i);
            repeat (4) @(posedge sys_clk);
            chk(32'(combined_audio_out), 32'(^2'(i)));
        end
        wr(8'h00, 32'h0000_0011);
        repeat (4) @(posedge sys_clk);
        chk(32'(combined_audio_out), 32'h0000_0000);
        $display("test audio done");
        wr(8'h00, 32'h0000_0004);
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(card_reset), 32'h0000_0001);
        chk(32'(moved), 32'h0000_0000);
        $display("test reset line done");
        complete_run();
    end
endmodule
`default_nettype wire
